// >>> test/cfg_manager_model.sv
// Purpose: Behavioural power manager on the register port
// Assumes: Strobes are one-cycle pulses launched just after a rising edge
// Notes: Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module cfg_manager_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  input wire logic [7:0] cfgRdData,
  output logic cfgWrEn,
  output logic cfgRdEn,
  output logic [7:0] cfgAddr,
  output logic [7:0] cfgWrData
);
  // ****************************************
  // Bus cycles
  // ****************************************
  initial begin
    cfgWrEn = 1'b0;
    cfgRdEn = 1'b0;
    cfgAddr = 8'h00;
    cfgWrData = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cfgWrEn <= 1'b1;
    cfgAddr <= a;
    cfgWrData <= d;
    @(posedge clk_sys);
    cfgWrEn <= 1'b0;
    cfgAddr <= ~a;
    cfgWrData <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    cfgRdEn <= 1'b1;
    cfgAddr <= a;
    @(posedge clk_sys);
    cfgRdEn <= 1'b0;
    cfgAddr <= ~a;
  endtask : rd

  // Limit change keeps droop and compensation bits as read back
  task automatic rmw(input logic [3:0] c);
    logic [7:0] v;
    rd(8'h08);
    @(posedge clk_sys);
    v = cfgRdData;
    wr(8'h08, {v[7:4], c});
  endtask : rmw
endmodule : cfg_manager_model
`default_nettype wire

// >>> test/tb_top.sv
// Purpose: Self-checking bench for the protection configuration block
// Assumes: Manager model drives the register port
// Notes: Read results are matched against a queue of expected bytes
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  import pol_prot_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, runEn = 1'b0, tempValid = 1'b0;
  logic ocDet = 1'b0, otDet = 1'b0, trDet = 1'b0, rdSeen = 1'b0;
  logic cfgWrEn, cfgRdEn, cfgWrRefused, driveEn, shutdownReq, limitTempCompEn, fallSlewEn;
  logic thermalWarnFlag, outputInWindowFlag, faultClass, errorClass, pgPinOe;
  logic [7:0] cfgAddr, cfgWrData, cfgRdData, onDelayMs, offDelayMs, tempCode = 8'h19;
  logic [11:0] rampTarget = 12'h000, voutSetpoint = 12'h3E8, voutMeas = 12'h000;
  logic [12:0] ovThresh, uvThresh, pgHiThresh, pgLoThresh;
  logic [2:0] droopCode, riseRateSel, fallRateSel;
  logic [3:0] currentLimitCode;
  logic [7:0] expQ[$];
  logic [7:0] d, cur, m;
  int error_cnt = 0, n_checks = 0;
  int ovPct[4] = '{110, 120, 125, 130};
  int uvPct[4] = '{75, 80, 85, 90};
  int temps[5] = '{120, 121, 118, 117, 116};
  logic warnExp[5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

  always #12.5 clk_sys = ~clk_sys;

  pol_protection_config uut (.clk_sys, .reset, .cfgWrEn, .cfgRdEn, .cfgAddr, .cfgWrData,
    .cfgRdData, .cfgWrRefused, .runEn, .rampTarget, .voutSetpoint, .voutMeas, .tempCode,
    .tempValid, .ocDet, .otDet, .trDet, .driveEn, .shutdownReq, .ovThresh, .uvThresh,
    .pgHiThresh, .pgLoThresh, .droopCode, .limitTempCompEn, .currentLimitCode, .riseRateSel,
    .fallRateSel, .fallSlewEn, .onDelayMs, .offDelayMs, .thermalWarnFlag, .outputInWindowFlag,
    .faultClass, .errorClass, .pgPinOe);
  cfg_manager_model mgr (.clk_sys, .cfgRdData, .cfgWrEn, .cfgRdEn, .cfgAddr, .cfgWrData);

  // ****************************************
  // Readback scoreboard and helpers
  // ****************************************
  always @(posedge clk_sys) rdSeen <= cfgRdEn;
  always @(negedge clk_sys) begin
    if (rdSeen) begin
      m = (expQ.size() > 0) ? expQ.pop_front() : 8'hXX;
      `CHK(cfgRdData, m)
    end
  end

  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    mgr.rd(a);
  endtask : rdx

  task automatic thr(input logic [5:0] c);
    @(negedge clk_sys);
    `CHK(ovThresh, 13'(voutSetpoint * ovPct[c[3:2]] / 100))
    `CHK(uvThresh, 13'(voutSetpoint * uvPct[c[1:0]] / 100))
    `CHK(pgHiThresh, 13'(voutSetpoint * (c[5] ? 105 : 110) / 100))
    `CHK(pgLoThresh, 13'(voutSetpoint * (c[4] ? 95 : 90) / 100))
  endtask : thr

  task automatic summarize;
    if (error_cnt == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  initial begin
    #(25 * 20000);
    error_cnt++;
    summarize();
  end

  initial begin
    void'($urandom(32'hc170));
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    `CHK({droopCode, limitTempCompEn, currentLimitCode}, 8'h1B)
    rdx(8'h01, 8'h08);
    rdx(8'h08, 8'h1B);
    mgr.wr(8'h7E, 8'hAA);
    rdx(8'h7E, 8'h00);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys);
      voutSetpoint <= 12'($urandom);
      d = {2'($urandom), i[0], i[1], 4'(i)};
      mgr.wr(8'h01, d);
      rdx(8'h01, {2'b00, d[5:0]});
      thr(d[5:0]);
    end
    // Writes while running must leave the thresholds alone
    @(posedge clk_sys);
    runEn <= 1'b1;
    voutSetpoint <= 12'h3E8;
    mgr.wr(8'h01, 8'h00);
    @(negedge clk_sys);
    `CHK(cfgWrRefused, 1'b1)
    rdx(8'h01, 8'h3F);
    @(posedge clk_sys);
    voutMeas <= 12'h320;
    rampTarget <= 12'h2BC;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(driveEn, 1'b0)
    @(posedge clk_sys);
    rampTarget <= 12'h321;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(driveEn, 1'b1)
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_sys);
      tempCode <= 8'(temps[k]);
      tempValid <= 1'b1;
      @(posedge clk_sys);
      tempValid <= 1'b0;
      @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK(thermalWarnFlag, warnExp[k])
      `CHK({driveEn, shutdownReq, faultClass}, 3'b100)
      rdx(8'h23, {7'h3F, ~warnExp[k]});
    end
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      {trDet, otDet, ocDet} <= 3'(1 << k);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK({faultClass, errorClass, shutdownReq}, 3'b101)
      @(posedge clk_sys);
      {trDet, otDet, ocDet} <= 3'b000;
    end
    @(posedge clk_sys);
    runEn <= 1'b0;
    repeat (4) begin
      d = 8'($urandom);
      mgr.wr(8'h03, d);
      @(negedge clk_sys);
      `CHK({riseRateSel, fallSlewEn, fallRateSel}, d[6:0])
      rdx(8'h03, {1'b0, d[6:0]});
    end
    mgr.wr(8'h20, 8'hFF);
    mgr.wr(8'h21, 8'hFF);
    rdx(8'h21, 8'h96);
    @(negedge clk_sys);
    `CHK(offDelayMs < onDelayMs, 1'b1)
    rdx(8'h20, 8'hFF);
    // Steady at setpoint: OV 125%, UV 75%, PG 90..110%; errors set not to stop
    mgr.wr(8'h01, 8'h08);
    mgr.wr(8'h22, 8'h01);
    rdx(8'h22, 8'h01);
    @(posedge clk_sys);
    rampTarget <= 12'h3E8;
    voutMeas <= 12'h3E7;
    runEn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK({driveEn, faultClass, errorClass, outputInWindowFlag}, 4'b1000)
    @(posedge clk_sys);
    voutMeas <= 12'h4B0;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK({outputInWindowFlag, pgPinOe, driveEn, shutdownReq}, 4'b1110)
    rdx(8'h23, 8'h7D);
    @(posedge clk_sys);
    voutMeas <= 12'h2BC;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK({errorClass, faultClass, shutdownReq, driveEn}, 4'b1001)
    rdx(8'h23, 8'h3D);
    @(posedge clk_sys);
    voutMeas <= 12'h514;
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK({faultClass, shutdownReq, driveEn}, 3'b110)
    @(posedge clk_sys);
    runEn <= 1'b0;
    cur = 8'hA3;
    mgr.wr(8'h08, cur);
    for (int i = 0; i < 16; i++) begin
      expQ.push_back(cur);
      mgr.rmw(4'(i));
      cur = {cur[7:4], (i > 11) ? 4'hB : 4'(i)};
      @(negedge clk_sys);
      `CHK({droopCode, limitTempCompEn, currentLimitCode}, cur)
    end
    rdx(8'h08, cur);
    repeat (2) @(posedge clk_sys);
    `CHK(expQ.size(), 0)
    summarize();
  end
endmodule : tb_top
`default_nettype wire

// >>> verilog/pol_prot_pkg.sv
// Purpose: Constants for the protection and limit configuration block
// Assumes: Registers reached over the manager's single-wire decoder port
// Notes: Temperatures are whole degrees Celsius
//
// Behaviour
// - Hold off driving until the ramp target passes a pre-biased output.
// - Falling ramp rate is set separately from the rising ramp rate.
// - Largest turn-off delay is below the largest turn-on delay.
// - Warnings are thermal near-limit and power-good.
// - Warnings never shut down; they show in readable status and on their flag outputs; only power-good also shows on pgPinOe.
// - Faults: OC, OV, OT, tracking; error: UV; separate response fields.
// - Threshold register writable only while the run bit is zero.
// - Bit 5 picks PG upper 105/110%, bit 4 PG lower 95/90%.
// - Bits 3:2 pick OV level, bits 1:0 pick UV level.
// - OV, UV and PG thresholds follow the active output setpoint.
// - Bits 7:5 of current-limit register hold the droop code.
// - Bit 4 enables current-limit temperature compensation, default on.
// - Bits 3:0 set the current limit code, default 0xB.
// - Current-limit codes above eleven act as eleven.
// - Above 120 C raise the thermal warning and its status bit.
// - Thermal warning clears only below 117 C.
// - Status condition bits are active low.
package pol_prot_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_PROT = 8'h01;
  localparam logic [7:0] ADDR_TRACK = 8'h03;
  localparam logic [7:0] ADDR_CLIM = 8'h08;
  localparam logic [7:0] ADDR_ONDLY = 8'h20;
  localparam logic [7:0] ADDR_OFFDLY = 8'h21;
  localparam logic [7:0] ADDR_RESP = 8'h22;
  localparam logic [7:0] ADDR_STATUS = 8'h23;

  localparam logic [5:0] PROT_RST = 6'h08;
  localparam logic [7:0] TRACK_RST = 8'h1C;
  localparam logic [7:0] CLIM_RST = 8'h1B;
  localparam logic [7:0] DLY_RST = 8'h00;
  localparam logic [1:0] RESP_RST = 2'h3;

  // Field positions
  localparam int PG_HI_BIT = 5;
  localparam int PG_LO_BIT = 4;
  localparam int CL_TC_BIT = 4;
  localparam int TR_SC_BIT = 3;

  localparam logic [3:0] CL_MAX = 4'hB;
  localparam logic [7:0] OFF_DELAY_MAX = 8'h96;

  // ****************************************
  // Threshold percentages
  // ****************************************
  localparam logic [7:0] PCT_PG_HI_1 = 8'd105;
  localparam logic [7:0] PCT_PG_HI_0 = 8'd110;
  localparam logic [7:0] PCT_PG_LO_1 = 8'd95;
  localparam logic [7:0] PCT_PG_LO_0 = 8'd90;
  localparam logic [7:0] PCT_OV_0 = 8'd110;
  localparam logic [7:0] PCT_OV_1 = 8'd120;
  localparam logic [7:0] PCT_OV_2 = 8'd125;
  localparam logic [7:0] PCT_OV_3 = 8'd130;
  localparam logic [7:0] PCT_UV_0 = 8'd75;
  localparam logic [7:0] PCT_UV_1 = 8'd80;
  localparam logic [7:0] PCT_UV_2 = 8'd85;
  localparam logic [7:0] PCT_UV_3 = 8'd90;
  localparam logic [19:0] PCT_DIV = 20'd100;

  localparam logic [7:0] TEMP_WARN_SET_C = 8'd120;
  localparam logic [7:0] TEMP_WARN_CLR_C = 8'd117;

  // Status bit positions
  localparam int ST_TW = 0;
  localparam int ST_PG = 1;
  localparam int ST_OC = 2;
  localparam int ST_OV = 3;
  localparam int ST_OT = 4;
  localparam int ST_TR = 5;
  localparam int ST_UV = 6;

  typedef enum logic [1:0] {STAGE_OFF, STAGE_HOLD, STAGE_DRIVE} stage_t;

endpackage : pol_prot_pkg

// >>> verilog/pol_protection_config.sv
// Purpose: Protection thresholds, limits, warnings and pre-bias hold-off
// Assumes: Config port and analog codes come from logic on clk_sys
// Notes: Fault detectors for OC, OT and tracking live elsewhere
`timescale 1ns/1ps
`default_nettype none

module pol_protection_config
  import pol_prot_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Register port from the single-wire decoder
  input wire logic cfgWrEn,
  input wire logic cfgRdEn,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgWrData,
  output logic [7:0] cfgRdData,
  output logic cfgWrRefused,
  // Converter state
  input wire logic runEn,
  input wire logic [11:0] rampTarget,
  input wire logic [11:0] voutSetpoint,
  input wire logic [11:0] voutMeas,
  input wire logic [7:0] tempCode,
  input wire logic tempValid,
  input wire logic ocDet,
  input wire logic otDet,
  input wire logic trDet,
  // Stage control
  output logic driveEn,
  output logic shutdownReq,
  // Thresholds
  output logic [12:0] ovThresh,
  output logic [12:0] uvThresh,
  output logic [12:0] pgHiThresh,
  output logic [12:0] pgLoThresh,
  // Limits and ramps
  output logic [2:0] droopCode,
  output logic limitTempCompEn,
  output logic [3:0] currentLimitCode,
  output logic [2:0] riseRateSel,
  output logic [2:0] fallRateSel,
  output logic fallSlewEn,
  output logic [7:0] onDelayMs,
  output logic [7:0] offDelayMs,
  // Indications
  output logic thermalWarnFlag,
  output logic outputInWindowFlag,
  output logic faultClass,
  output logic errorClass,
  output logic pgPinOe
);

  // ****************************************
  // Storage
  // ****************************************
  logic [5:0] prot_q;
  logic [7:0] track_q;
  logic [7:0] clim_q;
  logic [7:0] onDly_q;
  logic [7:0] offDly_q;
  logic [1:0] resp_q;
  stage_t stage_q;
  logic [6:0] statusVal;
  logic wrProt;
  logic [3:0] clCode;
  logic steady;
  logic ovDet;
  logic uvDet;
  logic pgBad;
  logic fltAny;
  logic errAny;

  function automatic logic [12:0] pctOf(input logic [11:0] sp,
                                        input logic [7:0] pct);
    logic [19:0] prod;
    prod = 20'(sp) * 20'(pct);
    pctOf = 13'(prod / PCT_DIV);
  endfunction : pctOf

  function automatic logic [7:0] ovPct(input logic [1:0] sel);
    unique case (sel)
      2'h0: ovPct = PCT_OV_0;
      2'h1: ovPct = PCT_OV_1;
      2'h2: ovPct = PCT_OV_2;
      2'h3: ovPct = PCT_OV_3;
    endcase
  endfunction : ovPct

  function automatic logic [7:0] uvPct(input logic [1:0] sel);
    unique case (sel)
      2'h0: uvPct = PCT_UV_0;
      2'h1: uvPct = PCT_UV_1;
      2'h2: uvPct = PCT_UV_2;
      2'h3: uvPct = PCT_UV_3;
    endcase
  endfunction : uvPct

  assign wrProt = cfgWrEn && (cfgAddr == ADDR_PROT);
  // Codes above the top step saturate before storage
  assign clCode = (cfgWrData[3:0] > CL_MAX) ? CL_MAX : cfgWrData[3:0];

  // ****************************************
  // Register writes
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prot_q <= PROT_RST;
    end else if (wrProt && !runEn) begin
      prot_q <= cfgWrData[5:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfgWrRefused <= 1'b0;
    end else begin
      cfgWrRefused <= wrProt && runEn;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      track_q <= TRACK_RST;
      clim_q <= CLIM_RST;
      onDly_q <= DLY_RST;
      offDly_q <= DLY_RST;
      resp_q <= RESP_RST;
    end else if (cfgWrEn) begin
      unique case (cfgAddr)
        ADDR_TRACK: track_q <= {1'b0, cfgWrData[6:0]};
        ADDR_CLIM: clim_q <= {cfgWrData[7:4], clCode};
        ADDR_ONDLY: onDly_q <= cfgWrData;
        // Turn-off delay clamps below the turn-on range
        ADDR_OFFDLY: offDly_q <= (cfgWrData > OFF_DELAY_MAX) ? OFF_DELAY_MAX : cfgWrData;
        ADDR_RESP: resp_q <= cfgWrData[1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    droopCode = clim_q[7:5];
    limitTempCompEn = clim_q[CL_TC_BIT];
    currentLimitCode = clim_q[3:0];
    riseRateSel = track_q[6:4];
    fallRateSel = track_q[2:0];
    fallSlewEn = track_q[TR_SC_BIT];
    onDelayMs = onDly_q;
    offDelayMs = offDly_q;
  end

  // ****************************************
  // Register reads
  // ****************************************
  // Active-low condition bits
  assign statusVal = ~{errorClass && uvDet, trDet, otDet, ovDet, ocDet,
                       outputInWindowFlag, thermalWarnFlag};

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfgRdData <= 8'h00;
    end else if (cfgRdEn) begin
      unique case (cfgAddr)
        ADDR_PROT: cfgRdData <= {2'b00, prot_q};
        ADDR_TRACK: cfgRdData <= track_q;
        ADDR_CLIM: cfgRdData <= clim_q;
        ADDR_ONDLY: cfgRdData <= onDly_q;
        ADDR_OFFDLY: cfgRdData <= offDly_q;
        ADDR_RESP: cfgRdData <= {6'h00, resp_q};
        ADDR_STATUS: cfgRdData <= {1'b0, statusVal};
        default: cfgRdData <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Thresholds
  // ****************************************
  // Recomputed every cycle so margining moves them too
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ovThresh <= 13'h0000;
      uvThresh <= 13'h0000;
      pgHiThresh <= 13'h0000;
      pgLoThresh <= 13'h0000;
    end else begin
      ovThresh <= pctOf(voutSetpoint, ovPct(prot_q[3:2]));
      uvThresh <= pctOf(voutSetpoint, uvPct(prot_q[1:0]));
      pgHiThresh <= pctOf(voutSetpoint,
        prot_q[PG_HI_BIT] ? PCT_PG_HI_1 : PCT_PG_HI_0);
      pgLoThresh <= pctOf(voutSetpoint,
        prot_q[PG_LO_BIT] ? PCT_PG_LO_1 : PCT_PG_LO_0);
    end
  end

  // ****************************************
  // Condition classes
  // ****************************************
  assign steady = driveEn && (rampTarget == voutSetpoint);
  assign ovDet = driveEn && (13'(voutMeas) > ovThresh);
  assign uvDet = steady && !ocDet && (13'(voutMeas) < uvThresh);
  assign pgBad = steady && ((13'(voutMeas) > pgHiThresh) ||
                            (13'(voutMeas) < pgLoThresh));
  assign fltAny = ocDet || ovDet || otDet || trDet;
  assign errAny = uvDet;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      faultClass <= 1'b0;
      errorClass <= 1'b0;
      shutdownReq <= 1'b0;
    end else begin
      faultClass <= fltAny;
      errorClass <= errAny;
      // Warnings are deliberately absent from the stop term
      shutdownReq <= (fltAny && resp_q[0]) || (errAny && resp_q[1]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      outputInWindowFlag <= 1'b0;
      pgPinOe <= 1'b0;
    end else begin
      outputInWindowFlag <= pgBad;
      pgPinOe <= pgBad;
    end
  end

  // ****************************************
  // Thermal warning
  // ****************************************
  // Between the two levels the flag keeps its value
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      thermalWarnFlag <= 1'b0;
    end else if (tempValid) begin
      if (tempCode > TEMP_WARN_SET_C) begin
        thermalWarnFlag <= 1'b1;
      end else if (tempCode < TEMP_WARN_CLR_C) begin
        thermalWarnFlag <= 1'b0;
      end
    end
  end

  // ****************************************
  // Pre-bias hold-off
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stage_q <= STAGE_OFF;
      driveEn <= 1'b0;
    end else begin
      unique case (stage_q)
        STAGE_OFF: begin
          if (runEn) begin
            stage_q <= STAGE_HOLD;
          end
        end
        STAGE_HOLD: begin
          if (!runEn) begin
            stage_q <= STAGE_OFF;
          end else if (rampTarget > voutMeas) begin
            stage_q <= STAGE_DRIVE;
            driveEn <= 1'b1;
          end
        end
        STAGE_DRIVE: begin
          if (!runEn || shutdownReq) begin
            stage_q <= STAGE_OFF;
            driveEn <= 1'b0;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_PREBIAS: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(driveEn) |-> $past(rampTarget > voutMeas))
    else $error("drive started below pre-bias level");

  AST_FALL_INDEP: assert property (@(posedge clk_sys) disable iff (reset)
    cfgWrEn && cfgAddr == ADDR_TRACK |=> fallRateSel == $past(cfgWrData[2:0])
      && riseRateSel == $past(cfgWrData[6:4]))
    else $error("ramp rates not stored separately");

  AST_OFF_DELAY: assert property (@(posedge clk_sys) disable iff (reset)
    offDelayMs <= OFF_DELAY_MAX)
    else $error("turn-off delay above its limit");

  AST_WARN_NO_STOP: assert property (@(posedge clk_sys) disable iff (reset)
    shutdownReq |-> faultClass || errorClass)
    else $error("stop without fault or error");

  AST_PROT_LOCK: assert property (@(posedge clk_sys) disable iff (reset)
    wrProt && runEn |=> $stable(prot_q) ##0 cfgWrRefused)
    else $error("threshold register changed while running");

  AST_PROT_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
    wrProt && !runEn |=> prot_q == $past(cfgWrData[5:0]))
    else $error("threshold write lost");

  AST_OV_FOLLOW: assert property (@(posedge clk_sys) disable iff (reset)
    !reset |=> ovThresh == pctOf($past(voutSetpoint), ovPct($past(prot_q[3:2]))))
    else $error("overvoltage level not tracking setpoint");

  AST_CL_SAT: assert property (@(posedge clk_sys) disable iff (reset)
    cfgWrEn && cfgAddr == ADDR_CLIM && cfgWrData[3:0] > CL_MAX
      |=> currentLimitCode == CL_MAX)
    else $error("current limit not saturated");

  AST_OT_SET: assert property (@(posedge clk_sys) disable iff (reset)
    tempValid && tempCode > TEMP_WARN_SET_C |=> thermalWarnFlag && !statusVal[ST_TW])
    else $error("thermal warning not raised");

  AST_OT_HYST: assert property (@(posedge clk_sys) disable iff (reset)
    thermalWarnFlag && !(tempValid && tempCode < TEMP_WARN_CLR_C) |=> thermalWarnFlag)
    else $error("thermal warning cleared early");

  AST_STATUS_LOW: assert property (@(posedge clk_sys) disable iff (reset)
    outputInWindowFlag |-> !statusVal[ST_PG])
    else $error("status bit not active low");

  COV_HOLD_DRIVE: cover property (@(posedge clk_sys) disable iff (reset)
    stage_q == STAGE_HOLD ##[1:20] driveEn);
  COV_REFUSED: cover property (@(posedge clk_sys) disable iff (reset)
    cfgWrRefused);
  COV_THERMAL: cover property (@(posedge clk_sys) disable iff (reset)
    $fell(thermalWarnFlag));
  COV_STOP: cover property (@(posedge clk_sys) disable iff (reset)
    $rose(shutdownReq));

endmodule : pol_protection_config

`default_nettype wire
